// ---- bench/mbw_master.sv ----
`timescale 1ns/100ps

// Bus master stand-in: sends request bytes, takes reply bytes
module mbw_master (
	input  wire logic       core_clk,
	input  wire logic       stall,     // Slow reply sink when high
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_last,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data
);
	logic [8:0] req_q[$];  // Bytes to send, bit 8 marks frame end
	logic [7:0] rep_q[$];  // Reply bytes taken so far
	logic       hold;      // Stall as seen at the edge

	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		rx_last  = 1'b0;
		tx_ready = 1'b0;
	end

	// Take units at the edge, change lines just after it
	always @(posedge core_clk) begin
		hold = stall;
		if (rx_valid && rx_ready === 1'b1 && req_q.size() > 0) begin
			req_q.delete(0);
		end
		if (tx_valid === 1'b1 && tx_ready) begin
			rep_q.push_back(tx_data);
		end
		#1;
		tx_ready = !hold;
		if (req_q.size() > 0) begin
			rx_valid = 1'b1;
			rx_data  = req_q[0][7:0];
			rx_last  = req_q[0][8];
		end else begin
			// Released line never keeps the old byte
			rx_valid = 1'b0;
			rx_data  = ~rx_data;
			rx_last  = 1'b0;
		end
	end
endmodule : mbw_master

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps

module tb_top
	import mbw_pkg::*;
;
	typedef logic [7:0] mbw_bq_t[$];
	logic        core_clk = 1'b0;
	logic        rstn, ascii_mode_pin, stall, stall_en;
	logic [7:0]  own_addr_pin, own;
	logic        rx_valid, rx_ready, rx_last, reg_wr, frame_drop, tx_valid, tx_ready, saw_full;
	logic [7:0]  rx_data, tx_data;
	logic [15:0] reg_addr, reg_data;
	logic [31:0] got_wr[$], exp_wr[$], r;  // Writes seen and expected
	mbw_bq_t     exp_rep;                  // Expected reply bytes
	mbw_bq_t     corner;                   // Hand-made spoiled frame
	logic [7:0]  grp_own [4];              // Own addresses at group edges
	int          got_drop, exp_drop, n_errors, check_count;
	int          seed = 32'h802b;

	// 20 MHz clock
	always #25 core_clk = ~core_clk;

	mbw_slave dut (.core_clk(core_clk), .rstn(rstn), .ascii_mode_pin(ascii_mode_pin),
		.own_addr_pin(own_addr_pin), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.rx_last(rx_last), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_data(reg_data),
		.frame_drop(frame_drop), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

	mbw_master partner (.core_clk(core_clk), .stall(stall), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

	// Result monitor and random reply stall
	always @(posedge core_clk) begin
		if (reg_wr === 1'b1) got_wr.push_back({reg_addr, reg_data});
		if (frame_drop === 1'b1) got_drop++;
		if (rx_ready === 1'b0) saw_full = 1'b1;
		#1 stall = stall_en & ($random(seed) % 3 == 0);
	end

	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;  // Upper case only
	endfunction : hexc

	// Whole frame with its check; bad flips one check bit
	function automatic mbw_bq_t encode(input logic asc, input mbw_bq_t b, input logic bad);
		mbw_bq_t     f;
		logic [15:0] c;
		logic [7:0]  l;
		c = 16'hffff;
		l = 8'h00;
		foreach (b[i]) begin
			l = l + b[i];
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		l = 8'hff - l + 8'h01 ^ {7'h00, bad};
		c = c ^ {15'h0000, bad};
		if (!asc) return {b, c[7:0], c[15:8]};
		b.push_back(l);
		f = {8'h3a};
		foreach (b[i]) f = {f, hexc(b[i][7:4]), hexc(b[i][3:0])};
		return {f, 8'h0d, 8'h0a};
	endfunction : encode

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic set_mode(input logic m, input logic [7:0] a);
		@(posedge core_clk);
		#1;
		ascii_mode_pin = m;
		own_addr_pin   = a;
		own            = a;
		repeat (4) @(posedge core_clk);
	endtask : set_mode

	// Queue one request and note what it should cause
	task automatic send(input logic [7:0] a, input logic [7:0] fn, input logic [31:0] v, input logic bad);
		mbw_bq_t b, f;
		logic    ok;
		b  = {a, fn, v[31:24], v[23:16], v[15:8], v[7:0]};
		f  = encode(ascii_mode_pin, b, bad);
		ok = !bad && fn == 8'h06 && (a == 8'h00 || a == own || a == ((own - 8'h01) >> 4) + 8'hf1);
		if (ok) exp_wr.push_back(v);
		else exp_drop++;
		if (ok && a == own) exp_rep = {exp_rep, encode(ascii_mode_pin, b, 1'b0)};
		foreach (f[i]) partner.req_q.push_back({!ascii_mode_pin && i == f.size() - 1, f[i]});
	endtask : send

	// Let queued traffic finish, then compare everything
	task automatic settle();
		int t;
		t = 0;
		while (t < 5000 && (partner.req_q.size() != 0 || got_wr.size() + got_drop < exp_wr.size() + exp_drop
			|| partner.rep_q.size() < exp_rep.size())) begin
			@(posedge core_clk);
			t++;
		end
		check("settle time", t < 5000, 1'b1);
		repeat (12) @(posedge core_clk);
		check("write count", got_wr.size(), exp_wr.size());
		check("drop count", got_drop, exp_drop);
		check("reply length", partner.rep_q.size(), exp_rep.size());
		foreach (got_wr[i]) if (i < exp_wr.size()) check("write addr data", got_wr[i], exp_wr[i]);
		foreach (exp_rep[i]) if (i < partner.rep_q.size()) check("reply byte", partner.rep_q[i], exp_rep[i]);
		got_wr.delete();
		exp_wr.delete();
		exp_rep.delete();
		partner.rep_q.delete();
		got_drop = 0;
		exp_drop = 0;
	endtask : settle

	task automatic end_of_test();
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Hang guard, well past the expected run length
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		end_of_test();
	end

	initial begin
		rstn = 1'b0;
		ascii_mode_pin = 1'b0;
		own_addr_pin = 8'hf0;
		own = 8'hf0;
		stall = 1'b0;
		stall_en = 1'b0;
		saw_full = 1'b0;
		repeat (5) @(posedge core_clk);
		#1 rstn = 1'b1;
		check("idle outputs", {rx_ready, reg_wr, frame_drop, tx_valid}, 4'h8);
		// Back-to-back mix in both framings; fills the receive buffer
		for (int m = 0; m < 2; m++) begin
			set_mode(m[0], 8'hf0);
			send(8'hf0, 8'h06, 32'h00801770, 1'b0);
			send(8'h00, 8'h06, 32'h12345678, 1'b0);
			send(8'hff, 8'h06, 32'h0081abcd, 1'b0);
			send(8'hfe, 8'h06, 32'h00820001, 1'b0);
			send(8'hf0, 8'h06, 32'h00830002, 1'b1);
			send(8'hf0, 8'h03, 32'h00800003, 1'b0);
			send(8'hef, 8'h06, 32'h00840004, 1'b0);
			if (m == 1) begin
				// Noise before the colon is ignored; a lower-case digit spoils a frame
				partner.req_q.push_back(9'h05a);
				send(8'hf0, 8'h06, 32'h00850005, 1'b0);
				corner = encode(1'b1, '{8'hf0, 8'h06, 8'h00, 8'h86, 8'h00, 8'haa}, 1'b0);
				corner[12] = 8'h61;
				foreach (corner[i]) partner.req_q.push_back({1'b0, corner[i]});
				exp_drop++;
			end
			settle();
		end
		check("receive buffer refused", saw_full, 1'b1);
		// Group edges: first and last member of a group
		grp_own = '{8'h01, 8'h10, 8'h11, 8'he1};
		foreach (grp_own[i]) begin
			set_mode(i[0], grp_own[i]);
			send(8'hf1, 8'h06, 32'h0100beef, 1'b0);
			send(8'hf2, 8'h06, 32'h0101cafe, 1'b0);
			send(own, 8'h06, 32'hffff0000, 1'b0);
			settle();
		end
		// Random traffic with a stalling reply sink
		stall_en = 1'b1;
		for (int n = 0; n < 40; n++) begin
			r = $random(seed);
			set_mode(r[0], 8'h01 + r[15:8] % 8'hf0);
			send(r[17] ? r[31:24] : (r[16] ? own : 8'h00), r[19:18] == 2'h0 ? 8'h03 : 8'h06, $random(seed),
				r[22:20] == 3'h0);
			settle();
		end
		end_of_test();
	end
endmodule : tb_top

// ---- rtl/mbw_pkg.sv ----
package mbw_pkg;
	// Command and address plan
	localparam logic [7:0]  FUNC_WRITE    = 8'h06;   // Write one holding register
	localparam logic [7:0]  ADDR_GLOBAL   = 8'h00;   // Everyone listens
	localparam logic [7:0]  ADDR_IND_MAX  = 8'hf0;   // Last individual address (240)
	localparam logic [7:0]  ADDR_GRP_BASE = 8'hf1;   // First group address (241)
	localparam int          GRP_SHIFT     = 4;       // Sixteen units per group
	// Error checks
	localparam logic [15:0] CRC_INIT      = 16'hffff;
	localparam logic [15:0] CRC_POLY      = 16'ha001;
	localparam logic [3:0]  CRC_STEPS     = 4'h8;    // Shifts per byte
	localparam logic [7:0]  LRC_BASE      = 8'hff;
	// Character codes
	localparam logic [7:0]  CHR_COLON     = 8'h3a;
	localparam logic [7:0]  CHR_CR        = 8'h0d;
	localparam logic [7:0]  CHR_LF        = 8'h0a;
	localparam logic [7:0]  CHR_ZERO      = 8'h30;
	localparam logic [7:0]  CHR_NINE      = 8'h39;
	localparam logic [7:0]  CHR_A         = 8'h41;
	localparam logic [7:0]  CHR_F         = 8'h46;
	localparam logic [7:0]  CHR_A_OFS     = 8'h37;   // 'A' minus ten
	// Frame lengths in bytes, after hex pairing
	localparam logic [3:0]  LEN_BODY      = 4'h6;    // Address to data low
	localparam logic [3:0]  LEN_RTU       = 4'h8;    // Body plus CRC
	localparam logic [3:0]  LEN_ASC       = 4'h7;    // Body plus LRC
	// Reply lengths in characters
	localparam logic [4:0]  TX_LEN_RTU    = 5'h08;
	localparam logic [4:0]  TX_LEN_ASC    = 5'h11;   // Colon, 14 hex, CR, LF
	localparam logic [4:0]  TX_CR_IDX     = 5'h0f;
	localparam logic [4:0]  TX_LF_IDX     = 5'h10;
	// Receive buffer
	localparam int          FIFO_DEPTH    = 16;
	localparam int          FIFO_WIDTH    = 9;       // Byte plus frame end mark

	typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_CHECK, ST_WRITE, ST_TX} mbw_state_t;
endpackage : mbw_pkg

// ---- rtl/mbw_slave.sv ----
`timescale 1ns/100ps

// Receive buffer, power of two depth
module mbw_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("mbw_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];   // Storage
	logic [AW:0]      wp_r;          // Write pointer, wrap bit on top
	logic [AW:0]      rp_r;          // Read pointer

	// Full when pointers differ only in wrap bit
	assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign out_data  = mem[rp_r[AW-1:0]];

	// Storage write, no reset needed
	always_ff @(posedge core_clk) begin
		if (in_valid && in_ready) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
			if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
		end
	end
endmodule : mbw_fifo

// How it works
// R1: Function 06 writes value to addressed register
// R2: Broadcast write hits same register everywhere
// R3: LRC skips colon and CR/LF
// R4: LRC sum eight bits, carry dropped
// R5: LRC is FF minus sum plus one
// R6: CRC register starts at FFFF
// R7: Each byte XORed into CRC low byte
// R8: Shift right, XOR A001 if LSB set
// R9: Eight shift steps per byte
// R10: Final CRC register is check value
// R11: CRC sent low byte first
// R12: Group address: act, no reply
// R13: Global address 0: act, no reply
// R14: Individual addresses 1 to 240
// R15: Groups 241 to 255, sixteen each
// R16: One global address besides groups
// R17: ASCII byte as two hex chars, high first
// R18: Accept RTU/CRC and ASCII/LRC frames
// R19: Individual write echoed with fresh check
// R20: Bad check or foreign address dropped silently
module mbw_slave
	import mbw_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        ascii_mode_pin,   // High selects ASCII framing
	input  wire logic [7:0]  own_addr_pin,     // Station address strap
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,          // RTU frame end mark with last byte
	output logic             reg_wr,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_data,
	output logic             frame_drop,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [7:0]  tx_data
);
	// Pin synchronisers
	logic        asc_s1, asc_r;
	logic [7:0]  own_s1, own_r;
	// Frame state
	mbw_state_t  state_r;
	logic [3:0]  step_r;        // CRC shift counter
	logic        end_r;         // Last RTU byte seen
	logic        hit_own_r;     // Addressed individually
	logic [15:0] crc_r, crc_keep_r;
	logic [7:0]  sum_r, sum_keep_r;
	logic [7:0]  buf_r [8];     // Received bytes
	logic [3:0]  cnt_r;         // Bytes received, saturating
	logic        bad_r;         // Non-hex character seen
	logic        in_frm_r;      // ASCII frame open
	logic        half_r;        // High nibble held
	logic [3:0]  hi_r;
	// Reply
	logic [4:0]  tx_idx_r;
	logic        tx_valid_r, reg_wr_r, drop_r;
	logic [7:0]  tx_data_r;
	logic [15:0] reg_addr_r, reg_data_r;

	// Buffer in the receive path; pops stall outside idle
	logic       f_valid, f_ready;
	logic [8:0] f_data;
	mbw_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   ({rx_last, rx_data}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);
	assign f_ready = (state_r == ST_IDLE);

	// Two flops on every strap
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			asc_s1 <= 1'b0;
			asc_r  <= 1'b0;
			own_s1 <= 8'h00;
			own_r  <= 8'h00;
		end else begin
			asc_s1 <= ascii_mode_pin;
			asc_r  <= asc_s1;
			own_s1 <= own_addr_pin;
			own_r  <= own_s1;
		end
	end

	// Byte decode
	logic       pop, is_hex, colon, asc_full, store_en, frm_clr, tx_adv;
	logic [7:0] b, store_byte, hex_off;
	logic [3:0] nib;
	assign pop      = f_valid && f_ready;
	assign b        = f_data[7:0];
	assign colon    = pop && asc_r && (b == CHR_COLON);
	assign is_hex   = (b >= CHR_ZERO && b <= CHR_NINE) || (b >= CHR_A && b <= CHR_F);
	assign hex_off  = (b <= CHR_NINE) ? (b - CHR_ZERO) : (b - CHR_A_OFS);
	assign nib      = hex_off[3:0];
	assign asc_full = pop && asc_r && in_frm_r && is_hex && half_r;   // [R17]
	assign store_en = (pop && !asc_r) || asc_full;   // [R18]
	assign store_byte = asc_r ? {hi_r, nib} : b;
	assign tx_adv   = !tx_valid_r || tx_ready;

	// Address match
	logic [7:0] own_m1, grp_sel;
	logic       own_ok, indiv, grp, glob, frm_ok;
	logic [4:0] tx_len;
	assign own_m1  = own_r - 8'h01;
	assign grp_sel = buf_r[0] - ADDR_GRP_BASE;
	assign own_ok  = (own_r != ADDR_GLOBAL) && (own_r <= ADDR_IND_MAX);   // [R14]
	assign indiv   = own_ok && (buf_r[0] == own_r);
	assign grp     = own_ok && (buf_r[0] >= ADDR_GRP_BASE) && (grp_sel == (own_m1 >> GRP_SHIFT));   // [R15]
	assign glob    = (buf_r[0] == ADDR_GLOBAL);   // [R16]
	// Length, check, function and address all good
	assign frm_ok  = (asc_r ? (cnt_r == LEN_ASC && sum_r == 8'h00) : (cnt_r == LEN_RTU && crc_r == 16'h0000))
		&& !bad_r && (buf_r[1] == FUNC_WRITE) && (indiv || grp || glob);   // [R20] [R10]
	assign tx_len  = asc_r ? TX_LEN_ASC : TX_LEN_RTU;
	// Frame context cleared on colon, drop, silent finish or reply done
	assign frm_clr = colon || (state_r == ST_CHECK && !frm_ok) || (state_r == ST_WRITE && !hit_own_r)
		|| (state_r == ST_TX && tx_adv && tx_idx_r == tx_len);

	// Sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r   <= ST_IDLE;
			step_r    <= 4'h0;
			end_r     <= 1'b0;
			hit_own_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					step_r <= 4'h0;
					if (pop && !asc_r) begin
						end_r   <= f_data[8];
						state_r <= ST_SHIFT;
					end else if (pop && in_frm_r && b == CHR_LF) begin
						state_r <= ST_CHECK;
					end
				end
				ST_SHIFT: begin
					step_r <= step_r + 4'h1;
					if (step_r == CRC_STEPS - 4'h1) begin   // [R9]
						state_r <= end_r ? ST_CHECK : ST_IDLE;
					end
				end
				ST_CHECK: begin
					hit_own_r <= indiv;
					state_r   <= frm_ok ? ST_WRITE : ST_IDLE;   // [R20]
				end
				ST_WRITE: begin
					// Broadcasts act but stay silent
					state_r <= hit_own_r ? ST_TX : ST_IDLE;   // [R12] [R13]
				end
				ST_TX: begin
					if (tx_adv && tx_idx_r == tx_len) state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// CRC: preset, fold byte, eight shift steps
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			crc_r      <= CRC_INIT;
			crc_keep_r <= CRC_INIT;
		end else begin
			if (frm_clr) begin
				crc_r <= CRC_INIT;   // [R6]
			end else if (pop && !asc_r) begin
				crc_r <= crc_r ^ {8'h00, b};   // [R7]
			end else if (state_r == ST_SHIFT) begin
				crc_r <= crc_r[0] ? ((crc_r >> 1) ^ CRC_POLY) : (crc_r >> 1);   // [R8]
			end
			// Snapshot after body: fresh check for the echo
			if (pop && !asc_r && cnt_r == LEN_BODY) crc_keep_r <= crc_r;   // [R10] [R19]
		end
	end

	// LRC sum and byte store; in ASCII framing colon, CR, LF never reach the sum
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sum_r      <= 8'h00;
			sum_keep_r <= 8'h00;
			cnt_r      <= 4'h0;
		end else if (frm_clr) begin
			sum_r <= 8'h00;
			cnt_r <= 4'h0;
		end else if (store_en) begin
			sum_r <= sum_r + store_byte;   // [R3] [R4]
			if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
			if (cnt_r == LEN_BODY) sum_keep_r <= sum_r;
		end
	end

	// Byte buffer; overflow bytes only counted
	always_ff @(posedge core_clk) begin
		if (store_en && !cnt_r[3]) buf_r[cnt_r[2:0]] <= store_byte;
	end

	// ASCII character framing, high nibble first
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			in_frm_r <= 1'b0;
			half_r   <= 1'b0;
			hi_r     <= 4'h0;
			bad_r    <= 1'b0;
		end else if (colon) begin
			in_frm_r <= 1'b1;
			half_r   <= 1'b0;
			bad_r    <= 1'b0;
		end else if (pop && asc_r && in_frm_r) begin
			if (b == CHR_LF) begin
				in_frm_r <= 1'b0;
			end else if (b == CHR_CR) begin
				half_r <= half_r;
			end else if (!is_hex) begin
				bad_r <= 1'b1;
			end else begin
				hi_r   <= nib;   // [R17]
				half_r <= !half_r;
			end
		end else if (frm_clr) begin
			bad_r <= 1'b0;
		end
	end

	// Register write strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_wr_r   <= 1'b0;
			reg_addr_r <= 16'h0000;
			reg_data_r <= 16'h0000;
			drop_r     <= 1'b0;
		end else begin
			reg_wr_r <= (state_r == ST_WRITE);   // [R1] [R2]
			drop_r   <= (state_r == ST_CHECK) && !frm_ok;
			if (state_r == ST_WRITE) begin
				reg_addr_r <= {buf_r[2], buf_r[3]};
				reg_data_r <= {buf_r[4], buf_r[5]};
			end
		end
	end

	// Reply character select
	logic [7:0] lrc_tx, rb, tx_char, cval;
	logic [4:0] t5;
	logic [3:0] cn;
	logic [2:0] k;
	assign lrc_tx = (LRC_BASE - sum_keep_r) + 8'h01;   // [R5]
	always_comb begin
		t5   = tx_idx_r - 5'h01;
		k    = asc_r ? t5[3:1] : tx_idx_r[2:0];
		// Byte first, then its nibble: the nibble must see this cycle's byte
		case (k)
			3'h6:    rb = asc_r ? lrc_tx : crc_keep_r[7:0];   // [R11]
			3'h7:    rb = crc_keep_r[15:8];
			default: rb = buf_r[k];
		endcase
		cn   = t5[0] ? rb[3:0] : rb[7:4];
		cval = (cn < 4'ha) ? (CHR_ZERO + {4'h0, cn}) : (CHR_A_OFS + {4'h0, cn});
		if (!asc_r) tx_char = rb;
		else if (tx_idx_r == 5'h00) tx_char = CHR_COLON;
		else if (tx_idx_r == TX_CR_IDX) tx_char = CHR_CR;
		else if (tx_idx_r == TX_LF_IDX) tx_char = CHR_LF;
		else tx_char = cval;   // [R17]
	end

	// Reply stream, echo of the write
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_idx_r   <= 5'h00;
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h00;
		end else if (state_r == ST_WRITE) begin
			tx_idx_r <= 5'h00;
		end else if (state_r == ST_TX && tx_adv) begin
			if (tx_idx_r == tx_len) begin
				tx_valid_r <= 1'b0;
			end else begin
				tx_data_r  <= tx_char;   // [R19]
				tx_valid_r <= 1'b1;
				tx_idx_r   <= tx_idx_r + 5'h01;
			end
		end
	end

	assign reg_wr     = reg_wr_r;
	assign reg_addr   = reg_addr_r;
	assign reg_data   = reg_data_r;
	assign frame_drop = drop_r;
	assign tx_valid   = tx_valid_r;
	assign tx_data    = tx_data_r;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_crc_preset: assert property (frm_clr |=> crc_r == CRC_INIT) // [R6]
		else $error("CRC not preset");
	a_shift_eight: assert property ($rose(state_r == ST_SHIFT) |-> (state_r == ST_SHIFT) [*8] ##1 state_r != ST_SHIFT) // [R9]
		else $error("Shift count wrong");
	a_shift_poly: assert property (state_r == ST_SHIFT && crc_r[0] && !frm_clr |=> crc_r[15] && !crc_r[0] == $past(crc_r[1])) // [R8]
		else $error("Poly XOR missing");
	a_shift_zero: assert property (state_r == ST_SHIFT && !crc_r[0] |=> !crc_r[15]) // [R8]
		else $error("MSB not zero filled");
	a_rtu_check: assert property (state_r == ST_WRITE && !asc_r |-> crc_r == 16'h0000) // [R10]
		else $error("RTU write with bad CRC");
	a_lrc_check: assert property (state_r == ST_WRITE && asc_r |-> sum_r == 8'h00) // [R4]
		else $error("ASCII write with bad LRC");
	a_write_func: assert property ($rose(reg_wr_r) |-> $past(buf_r[1] == FUNC_WRITE)) // [R1]
		else $error("Write without function 06");
	a_bcast_silent: assert property (state_r == ST_WRITE && !hit_own_r |=> !tx_valid_r [*2]) // [R12]
		else $error("Broadcast replied");
	a_tx_swap: assert property (tx_valid_r && !asc_r && tx_idx_r == 5'h08 |-> tx_data_r == crc_keep_r[15:8]) // [R11]
		else $error("CRC high byte not last");
	a_drop_quiet: assert property (drop_r |-> !reg_wr_r ##1 !tx_valid_r) // [R20]
		else $error("Dropped frame acted");

	c_rtu_write: cover property (reg_wr_r && !asc_r);
	c_asc_reply: cover property (tx_valid_r && asc_r && tx_ready && tx_data_r == CHR_LF);
	c_global: cover property (state_r == ST_WRITE && buf_r[0] == ADDR_GLOBAL);
	c_drop: cover property (drop_r);
endmodule : mbw_slave
